// *** hdl/cer_pkg.sv ***
// package: constants and types of the config crc error report block
package cer_pkg;
  // ==========================================================================
  // widths
  localparam int SYN_W    = 16;
  localparam int MSG_W    = 46;
  localparam int INJ_W    = 21;
  localparam int TYPE_W   = 4;
  localparam int LOC_W    = 26;
  // ==========================================================================
  // error message field layout: {type, location, syndrome}
  localparam int MSG_SYN_LSB  = 0;
  localparam int MSG_LOC_LSB  = 16;
  localparam int MSG_TYPE_LSB = 42;
  // ==========================================================================
  // error type codes
  localparam logic [3:0] ETYPE_NONE   = 4'h0;
  localparam logic [3:0] ETYPE_SINGLE = 4'h1;
  localparam logic [3:0] ETYPE_DOUBLE_ADJ = 4'h2;
  localparam logic [3:0] ETYPE_OTHER  = 4'h3;
  // ==========================================================================
  // reset values
  localparam logic [15:0] SYN_RST = 16'h0000;
  localparam logic [45:0] MSG_RST = 46'h0000_0000_0000;
  localparam logic [20:0] INJ_RST = 21'h00_0000;
  // ==========================================================================
  // timing
  localparam int FLAG_LOW_CYC  = 32;
  localparam int OSC_MHZ       = 100;
  localparam int DIV_EXP_MIN   = 1;
  localparam int DIV_EXP_MAX   = 8;
  localparam logic [3:0] DIV_EXP_RST = 4'h1;
  // ==========================================================================
  // jtag instruction codes
  localparam int IR_W = 4;
  localparam logic [3:0] IR_BYPASS     = 4'hf;
  localparam logic [3:0] IR_READ_EMSG  = 4'h5;
  localparam logic [3:0] IR_FAULT_INJ  = 4'h6;
  // ==========================================================================
  // report sequencer states, gray on each step except the return from CER_LOW to CER_IDLE
  typedef enum logic [1:0] {
    CER_IDLE   = 2'b00,
    CER_FLAG   = 2'b01,
    CER_LOW    = 2'b11
  } cer_state_t;
endpackage

// *** hdl/cer_sync.sv ***
// two-flop synchroniser into the destination clock
`timescale 1ns/1ps
`default_nettype none
module cer_sync #(
  parameter int W = 1
) (
  input  wire logic clk,
  input  wire logic srst,
  cer_sync_if.syn   s
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  always_comb begin
    meta_d = s.async_in;
    out_d  = meta_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      out_q  <= '0;
    end else begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign s.sync_out = out_q;
endmodule
`default_nettype wire

// *** hdl/cer_sync_if.sv ***
// interface: a two-flop synchroniser bundle between modules
`timescale 1ns/1ps
`default_nettype none
interface cer_sync_if #(parameter int W = 1);
  logic [W-1:0] async_in;
  logic [W-1:0] sync_out;
  modport src (output async_in, input sync_out);
  modport syn (input async_in, output sync_out);
endinterface
`default_nettype wire

// *** hdl/cer_top.sv ***
// config crc error report: syndrome, message, update/shift and fault inject registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - one 16-bit syndrome register captures each frame's crc signature
// - error flag output rises after a message update with a non-zero syndrome, and drops when the syndrome clears or the next update arrives
// - syndrome holds the frame signature through its verification cycle
// - 46-bit message register holds error type, location and syndrome
// - location reported only for single and double-adjacent errors, else zero
// - message readable over jtag read instruction and via core interface
// - user update register copies the message one cycle after it is valid, unless user_update_en is high
// - jtag shift register samples jtag update register, shifts out under read instruction
// - user shift register samples user update register for core logic reading
// - 21-bit jtag fault register accessible only under the inject instruction
// - jtag fault register copied into active fault register on update
// - flag raised after message update, then low at least 32 cycles
// - detection clock is 100 MHz divided by two to the 1..8
// - next error overwrites an unread message; read within one frame interval
module cer_top #(
  parameter logic [3:0] DIV_EXP = cer_pkg::DIV_EXP_RST
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        frame_done,
  input  wire logic [15:0] frame_syndrome,
  input  wire logic [3:0]  search_type,
  input  wire logic [25:0] search_location,
  input  wire logic        user_update_en,
  input  wire logic        user_shift_load,
  input  wire logic        user_shift_en,
  input  wire logic        tck,
  input  wire logic        tdi,
  input  wire logic [3:0]  ir_code,
  input  wire logic        capture_dr,
  input  wire logic        shift_dr,
  input  wire logic        update_dr,
  output logic             tdo,
  output logic             crc_error_o,
  output logic             crc_error_oe,
  output logic             det_clk_en,
  output logic [15:0]      crc_syndrome,
  output logic [45:0]      error_message_reg,
  output logic             user_shift_out,
  output logic [20:0]      fault_inject_active
);
  // ==========================================================================
  // detection clock divider: enable pulse every 2^n cycles of the source
  logic [7:0] div_cnt_q;
  logic [7:0] div_cnt_d;
  logic       det_en_q;
  logic       det_en_d;
  logic [7:0] div_max;

  always_comb begin
    div_max   = 8'((9'h001 << DIV_EXP) - 9'h001);
    div_cnt_d = (div_cnt_q >= div_max) ? 8'h00 : 8'(div_cnt_q + 8'h01);
    det_en_d  = (div_cnt_q >= div_max);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_q <= 8'h00;
      det_en_q  <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      det_en_q  <= det_en_d;
    end
  end

  // ==========================================================================
  // syndrome and error message registers
  logic [15:0] syn_q;
  logic [15:0] syn_d;
  logic [45:0] msg_q;
  logic [45:0] msg_d;
  logic        msg_upd_q;
  logic        msg_upd_d;
  logic [25:0] loc_kept;

  always_comb begin
    syn_d     = syn_q;
    msg_d     = msg_q;
    msg_upd_d = 1'b0;
    loc_kept  = ((search_type == cer_pkg::ETYPE_SINGLE) ||
                 (search_type == cer_pkg::ETYPE_DOUBLE_ADJ)) ? search_location
                                                             : 26'h000_0000;
    if (frame_done) begin
      syn_d = frame_syndrome;
      if (frame_syndrome != cer_pkg::SYN_RST) begin
        // overwrites any unread message, by design
        msg_d     = {search_type, loc_kept, frame_syndrome};
        msg_upd_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      syn_q     <= cer_pkg::SYN_RST;
      msg_q     <= cer_pkg::MSG_RST;
      msg_upd_q <= 1'b0;
    end else begin
      syn_q     <= syn_d;
      msg_q     <= msg_d;
      msg_upd_q <= msg_upd_d;
    end
  end

  // ==========================================================================
  // flag sequencer: high after update, then a guaranteed low gap
  cer_pkg::cer_state_t st_q;
  cer_pkg::cer_state_t st_d;
  logic [5:0]          low_cnt_q;
  logic [5:0]          low_cnt_d;
  logic                pend_q;
  logic                pend_d;
  logic                flag_q;
  logic                flag_d;

  always_comb begin
    st_d      = st_q;
    low_cnt_d = low_cnt_q;
    pend_d    = pend_q | msg_upd_q;
    flag_d    = 1'b0;
    unique case (st_q)
      cer_pkg::CER_IDLE: begin
        if (pend_d && (syn_q != cer_pkg::SYN_RST)) begin
          st_d   = cer_pkg::CER_FLAG;
          pend_d = 1'b0;
          flag_d = 1'b1;
        end
      end
      cer_pkg::CER_FLAG: begin
        flag_d = (syn_q != cer_pkg::SYN_RST) && !msg_upd_q;
        if (!flag_d) begin
          st_d      = cer_pkg::CER_LOW;
          low_cnt_d = 6'h00;
        end
      end
      cer_pkg::CER_LOW: begin
        low_cnt_d = 6'(low_cnt_q + 6'h01);
        if (low_cnt_q == 6'(cer_pkg::FLAG_LOW_CYC - 1)) begin
          st_d = cer_pkg::CER_IDLE;
        end
      end
      default: st_d = cer_pkg::CER_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q      <= cer_pkg::CER_IDLE;
      low_cnt_q <= 6'h00;
      pend_q    <= 1'b0;
      flag_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      low_cnt_q <= low_cnt_d;
      pend_q    <= pend_d;
      flag_q    <= flag_d;
    end
  end

  // ==========================================================================
  // user update and user shift registers
  logic [45:0] uupd_q;
  logic [45:0] uupd_d;
  logic [45:0] ushf_q;
  logic [45:0] ushf_d;

  always_comb begin
    uupd_d = uupd_q;
    ushf_d = ushf_q;
    // holding the enable freezes the copy while user logic samples
    if (msg_upd_q && !user_update_en) begin
      uupd_d = msg_q;
    end
    if (user_shift_load) begin
      ushf_d = uupd_q;
    end else if (user_shift_en) begin
      ushf_d = {1'b0, ushf_q[45:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      uupd_q <= cer_pkg::MSG_RST;
      ushf_q <= cer_pkg::MSG_RST;
    end else begin
      uupd_q <= uupd_d;
      ushf_q <= ushf_d;
    end
  end

  // ==========================================================================
  // message copy for the tck side: moves only on a message update, so a
  // capture kept away from an update sees a settled word
  logic [45:0] jupd_q;
  logic [45:0] jupd_d;

  always_comb begin
    jupd_d = msg_upd_q ? msg_q : jupd_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      jupd_q <= cer_pkg::MSG_RST;
    end else begin
      jupd_q <= jupd_d;
    end
  end

  // ==========================================================================
  // tck domain: jtag shift and fault inject registers
  // tck only runs during scans, so nothing here counts edges outside one
  logic [45:0] jshf_q;
  logic [45:0] jshf_d;
  logic [20:0] jinj_q;
  logic [20:0] jinj_d;
  logic        jinj_tog_q;
  logic        jinj_tog_d;
  logic        tdo_q;
  logic        tdo_d;
  logic        rd_sel;
  logic        inj_sel;

  always_comb begin
    rd_sel     = (ir_code == cer_pkg::IR_READ_EMSG);
    inj_sel    = (ir_code == cer_pkg::IR_FAULT_INJ);
    jshf_d     = jshf_q;
    jinj_d     = jinj_q;
    jinj_tog_d = jinj_tog_q;
    tdo_d      = tdi;
    if (rd_sel) begin
      // jupd_q is quiet for many tck periods between message updates
      if (capture_dr) begin
        jshf_d = jupd_q;
      end else if (shift_dr) begin
        jshf_d = {tdi, jshf_q[45:1]};
      end
      tdo_d = jshf_q[0];
    end else if (inj_sel) begin
      if (shift_dr) begin
        jinj_d = {tdi, jinj_q[20:1]};
      end else if (update_dr) begin
        jinj_tog_d = ~jinj_tog_q;
      end
      tdo_d = jinj_q[0];
    end
  end

  always_ff @(posedge tck) begin
    if (srst) begin
      jshf_q     <= cer_pkg::MSG_RST;
      jinj_q     <= cer_pkg::INJ_RST;
      jinj_tog_q <= 1'b0;
      tdo_q      <= 1'b0;
    end else begin
      jshf_q     <= jshf_d;
      jinj_q     <= jinj_d;
      jinj_tog_q <= jinj_tog_d;
      tdo_q      <= tdo_d;
    end
  end

  // ==========================================================================
  // inject update crossing back to clk; jinj_q stable after update_dr
  cer_sync_if #(.W(1)) inj_if ();
  assign inj_if.async_in = jinj_tog_q;

  cer_sync #(.W(1)) u_inj_sync (
    .clk  (clk),
    .srst (srst),
    .s    (inj_if)
  );

  logic        inj_seen_q;
  logic        inj_seen_d;
  logic [20:0] finj_q;
  logic [20:0] finj_d;

  always_comb begin
    inj_seen_d = inj_if.sync_out;
    finj_d     = (inj_if.sync_out != inj_seen_q) ? jinj_q : finj_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      inj_seen_q <= 1'b0;
      finj_q     <= cer_pkg::INJ_RST;
    end else begin
      inj_seen_q <= inj_seen_d;
      finj_q     <= finj_d;
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops
  assign tdo                 = tdo_q;
  assign crc_error_o         = flag_q;
  assign crc_error_oe        = flag_q;
  assign det_clk_en          = det_en_q;
  assign crc_syndrome        = syn_q;
  assign error_message_reg   = msg_q;
  assign user_shift_out      = ushf_q[0];
  assign fault_inject_active = finj_q;
endmodule
`default_nettype wire

// *** testbench/cer_host_model.sv ***
// jtag host model: capture, shift and update sequences on tck
`timescale 1ns/1ps
`default_nettype none
module cer_host_model (
  output logic       tck,
  output logic       tdi,
  output logic [3:0] ir_code,
  output logic       capture_dr,
  output logic       shift_dr,
  output logic       update_dr,
  input  wire logic  tdo
);
  // =======
  // tck stands low between sequences; tdi toggles when it carries nothing
  initial begin
    {tck, tdi, capture_dr, shift_dr, update_dr} = 5'h00;
    ir_code = cer_pkg::IR_BYPASS;
  end
  // rise lands 11 ns into the call, off the grid of clk edges
  task automatic pulse();
    #11 tck = 1'b1;
    #16 tck = 1'b0;
    tdi = ~tdi;
    #5;
  endtask
  task automatic read_msg(output logic [45:0] m);
    ir_code = cer_pkg::IR_READ_EMSG;
    capture_dr = 1'b1;
    pulse();
    capture_dr = 1'b0;
    shift_dr = 1'b1;
    for (int i = 0; i < 46; i++) begin
      pulse();
      m[i] = tdo;
    end
    shift_dr = 1'b0;
    ir_code = cer_pkg::IR_BYPASS;
  endtask
  task automatic inject(input logic [3:0] ir, input logic [20:0] v);
    ir_code = ir;
    shift_dr = 1'b1;
    for (int i = 0; i < 21; i++) begin
      tdi = v[i];
      pulse();
    end
    shift_dr = 1'b0;
    update_dr = 1'b1;
    pulse();
    update_dr = 1'b0;
    ir_code = cer_pkg::IR_BYPASS;
  endtask
endmodule
`default_nettype wire

// *** testbench/cer_top_properties.sv ***
// checker: port-level properties of the crc error report block
`timescale 1ns/1ps
`default_nettype none
module cer_top_properties #(
  parameter logic [3:0] DIV_EXP = cer_pkg::DIV_EXP_RST
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        frame_done,
  input wire logic [15:0] frame_syndrome,
  input wire logic [15:0] crc_syndrome,
  input wire logic [45:0] error_message_reg,
  input wire logic        crc_error_o,
  input wire logic        crc_error_oe,
  input wire logic        det_clk_en,
  input wire logic        user_shift_load
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [5:0] low_q, low_d;
  logic [9:0] dc_q, dc_d;
  // =======
  // helper counts: low_q starts full so the first report is free,
  // dc_q bit 9 marks no divider pulse seen yet
  always_comb begin
    low_d = crc_error_o ? 6'h00 : (low_q < 6'h20 ? low_q + 6'h01 : low_q);
    dc_d  = det_clk_en ? 10'h000 : dc_q + 10'h001;
    if (srst) begin
      low_d = 6'h20;
      dc_d  = 10'h200;
    end
  end
  always_ff @(posedge clk) begin
    low_q <= low_d;
    dc_q  <= dc_d;
  end
  // =======
  // properties
  syn_capture_a: assert property (frame_done |=> crc_syndrome == $past(frame_syndrome))
    else $error("syndrome not captured");
  flag_cause_a: assert property (crc_error_o |-> $past(crc_syndrome) != 16'h0000)
    else $error("flag without syndrome");
  oe_follow_a: assert property (crc_error_oe == crc_error_o)
    else $error("flag enable differs");
  syn_hold_a: assert property (!frame_done |=> $stable(crc_syndrome))
    else $error("syndrome changed mid cycle");
  msg_syn_a: assert property (frame_done && frame_syndrome != 16'h0000
    |=> error_message_reg[15:0] == $past(frame_syndrome)) else $error("message syndrome wrong");
  loc_blank_a: assert property (!(error_message_reg[45:42] inside {4'h1, 4'h2})
    |-> error_message_reg[41:16] == 26'h0) else $error("location not blank");
  flag_gap_a: assert property ($rose(crc_error_o) |-> low_q >= 6'h20)
    else $error("flag low gap short");
  flag_report_a: assert property (frame_done && frame_syndrome != 16'h0000
    |-> ##[1:40] crc_error_o) else $error("report flag missing");
  div_period_a: assert property (det_clk_en && !dc_q[9]
    |-> dc_q[8:0] == (9'h001 << DIV_EXP) - 9'h001) else $error("divider period wrong");
  cover property (frame_done && frame_syndrome != 16'h0000 ##2 frame_done);
  cover property ($fell(crc_error_o));
  cover property (user_shift_load);
endmodule
bind cer_top cer_top_properties #(.DIV_EXP(DIV_EXP)) u_props (.*);
`default_nettype wire

// *** testbench/config_crc_error_report_tb_top.sv ***
// testbench: frames, both message read routes and fault injection
`timescale 1ns/1ps
`default_nettype none
module config_crc_error_report_tb_top;
  logic        clk, srst, frame_done, user_update_en, user_shift_load, user_shift_en;
  logic        tck, tdi, capture_dr, shift_dr, update_dr, tdo, crc_error_o, crc_error_oe;
  logic        det_clk_en, user_shift_out;
  logic [3:0]  search_type, ir_code;
  logic [15:0] frame_syndrome, crc_syndrome;
  logic [25:0] search_location;
  logic [45:0] error_message_reg, exp_user, got;
  logic [20:0] fault_inject_active, inj;
  logic [45:0] msg_q[$];
  integer      fail_count, tests_run, seed, det_pulses;
  cer_top #(.DIV_EXP(4'h2)) dut (.*);
  cer_host_model host (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // =======
  // helpers
  task automatic chk(input logic [45:0] g, input logic [45:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic frame(input logic [15:0] s, input logic [3:0] t);
    @(posedge clk);
    frame_done <= 1'b1;
    frame_syndrome <= s;
    search_type <= t;
    search_location <= 26'($random(seed));
    @(posedge clk);
    frame_done <= 1'b0;
    // scrambled so a late capture would show
    frame_syndrome <= 16'($random(seed));
    if (s != 16'h0000) begin
      msg_q.push_back({t, (t == 4'h1 || t == 4'h2) ? search_location : 26'h0, s});
      if (!user_update_en) exp_user = msg_q[$];
    end
  endtask
  task automatic uread(output logic [45:0] m);
    @(posedge clk);
    user_update_en <= 1'b1;
    @(posedge clk);
    user_shift_load <= 1'b1;
    @(posedge clk);
    user_shift_load <= 1'b0;
    user_update_en <= 1'b0;
    for (int i = 0; i < 46; i++) begin
      repeat (2) @(posedge clk);
      m[i] = user_shift_out;
      user_shift_en <= 1'b1;
      @(posedge clk);
      user_shift_en <= 1'b0;
    end
  endtask
  // =======
  // main sequence
  initial begin
    seed = 19;
    fail_count = 0;
    tests_run = 0;
    srst = 1'b1;
    {frame_done, user_update_en, user_shift_load, user_shift_en} = 4'h0;
    {frame_syndrome, search_type, search_location, exp_user} = '0;
    fork
      host.pulse();
    join_none
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(error_message_reg, cer_pkg::MSG_RST);
    chk(crc_syndrome, cer_pkg::SYN_RST);
    chk(fault_inject_active, cer_pkg::INJ_RST);
    // dut runs with a divide exponent of 2: one pulse per 4 clk
    det_pulses = 0;
    repeat (64) begin
      @(posedge clk);
      det_pulses += det_clk_en;
    end
    chk(det_pulses, 64 >> 2);
    for (int t = 0; t < 5; t++) begin
      frame(16'($random(seed)) | 16'h0100, t[3:0]);
      // second error lands before the first is read
      if (t == 4) frame(16'($random(seed)) | 16'h0001, 4'h2);
      repeat (40) @(posedge clk);
      chk(crc_syndrome, msg_q[$][15:0]);
      chk(error_message_reg, msg_q[$]);
      chk(crc_error_o, 1'b1);
      chk(crc_error_oe, 1'b1);
      uread(got);
      chk(got, exp_user);
      host.read_msg(got);
      chk(got, msg_q[$]);
    end
    frame(16'h0000, 4'h1);
    repeat (4) @(posedge clk);
    chk(crc_syndrome, 16'h0000);
    chk(crc_error_o, 1'b0);
    chk(crc_error_oe, 1'b0);
    chk(error_message_reg, msg_q[$]);
    user_update_en <= 1'b1;
    frame(16'($random(seed)) | 16'h0010, 4'h3);
    repeat (4) @(posedge clk);
    user_update_en <= 1'b0;
    uread(got);
    chk(got, exp_user);
    inj = 21'($random(seed));
    host.inject(cer_pkg::IR_FAULT_INJ, inj);
    repeat (10) @(posedge clk);
    chk(fault_inject_active, inj);
    host.inject(cer_pkg::IR_BYPASS, ~inj);
    repeat (10) @(posedge clk);
    chk(fault_inject_active, inj);
    wrap_up();
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
